// *** shared/hcr_defines.svh ***
// timing counts, reset values and register map of the hub clock/reset block
`ifndef HCR_DEFINES_SVH
`define HCR_DEFINES_SVH
`define HCR_CLK_MHZ 50
`define HCR_CLKON_US 60
// cycles of 20 ns in the 60 us clock-active window before reset release
`define HCR_CLKON_CYC (`HCR_CLKON_US * `HCR_CLK_MHZ)
`define HCR_NUM_PORTS 3
`define HCR_DIV12 4
// 12 MHz ticks counted in settle before the core is let run
`define HCR_SETTLE_TICKS 4'hF
// longest board reset pulse the bench applies, 100 us in system cycles
`define HCR_RST_US 100
`define HCR_RST_CYC (`HCR_RST_US * `HCR_CLK_MHZ)
`define HCR_ADDR_CTRL 12'h000
`define HCR_ADDR_STAT 12'h004
`define HCR_CTRL_PWR_LSB 0
`define HCR_CTRL_SUSP_BIT 3
`define HCR_CTRL_RST 4'h0
`define HCR_STAT_MODE_BIT 0
`define HCR_STAT_NP_LSB 1
`define HCR_STAT_FIX_LSB 3
`define HCR_STAT_LOCK_BIT 5
`define HCR_STAT_ACT_LSB 6
`endif

// *** shared/hcr_pkg.sv ***
// types for the hub clock/reset/strap control block
package hcr_pkg;
  typedef enum logic [1:0] {HCR_PLL_CLK, HCR_DIRECT_CLK} hcr_clk_mode_t;
  typedef logic [2:0] hcr_port_mask_t;
  typedef enum {HCR_ST_RESET, HCR_ST_SETTLE, HCR_ST_RUN, HCR_ST_SUSP} hcr_state_t;
endpackage

// *** rtl/hcr_clock_gen.sv ***
// crystal drive and 12 MHz tick generation from reference edges
`timescale 1ns/100ps
`include "hcr_defines.svh"
module hcr_clock_gen (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mode_direct,
  input wire logic reference_clock_in,
  output logic crystal_drive_out,
  output logic tick12,
  output logic pll_lock
);
  import hcr_pkg::*;
  logic [1:0] div_r, div_nxt;
  logic ref_d_r, ref_d_nxt;
  logic lock_r, lock_nxt;
  logic drv_r, drv_nxt;
  logic tick_r, tick_nxt;
  // pll model: ref edges stand for the 48 MHz core, divided by 4 to 12 MHz
  always_comb begin
    ref_d_nxt = reference_clock_in;
    drv_nxt = mode_direct ? 1'b0 : ~reference_clock_in; // crystal inverter
    lock_nxt = lock_r | (ref_d_r != reference_clock_in);
    div_nxt = div_r;
    tick_nxt = 1'b0;
    if (ref_d_r != reference_clock_in) begin
      // direct mode counts ref edges the same way as pll mode, divided by 4
      div_nxt = div_r + 2'h1;
      tick_nxt = (div_r == 2'(`HCR_DIV12 - 1));
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_r <= 2'h0;
      ref_d_r <= 1'b0;
      lock_r <= 1'b0;
      drv_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ref_d_r <= ref_d_nxt;
      lock_r <= lock_nxt;
      drv_r <= drv_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign crystal_drive_out = drv_r;
  assign tick12 = tick_r;
  assign pll_lock = lock_r;
endmodule

// *** rtl/hcr_control.sv ***
// top: straps, reset sequencing, suspend flag, port power enables, apb
`timescale 1ns/100ps
`include "hcr_defines.svh"
module hcr_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mode_strap,
  input wire logic three_port_select_n,
  input wire logic [1:0] fixed_port_count,
  input wire logic reference_clock_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output hcr_pkg::hcr_port_mask_t port_power_enable_n,
  output logic suspend_status_out,
  output logic crystal_drive_out,
  output logic [1:0] active_port_count,
  output logic [1:0] fixed_port_report
);
  import hcr_pkg::*;
  hcr_state_t st_r, st_nxt;
  hcr_clk_mode_t cmode_r, cmode_nxt;
  logic np3_r, np3_nxt;
  logic [1:0] fix_r, fix_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  hcr_port_mask_t pwr_n_r, pwr_n_nxt;
  logic susp_r, susp_nxt;
  logic [1:0] act_r, act_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic rdy_r, rdy_nxt;
  logic err_r, err_nxt;
  logic tick12, pll_lock, mode_direct, xdrv;
  logic [3:0] hold_r, hold_nxt;
  logic settle_tick, acc_take, hit_ctrl, hit_stat;

  // mode is sampled at release and held, straps must not move in operation
  assign mode_direct = (cmode_r == HCR_DIRECT_CLK);

  hcr_clock_gen u_clk (
    .clk_sys(clk_sys),
    .reset(reset),
    .mode_direct(mode_direct),
    .reference_clock_in(reference_clock_in),
    .crystal_drive_out(xdrv),
    .tick12(tick12),
    .pll_lock(pll_lock)
  );

  // which ports exist for the current strap setting
  function automatic hcr_port_mask_t port_mask(input logic np3_n);
    port_mask = np3_n ? 3'h3 : 3'h7;
  endfunction

  function automatic logic apb_hit(input logic [11:0] a,
                                   input logic [11:0] r);
    apb_hit = (a == r);
  endfunction

  // number of downstream ports the hub offers for a strap level
  function automatic logic [1:0] port_total(input logic np3_n);
    port_total = np3_n ? 2'h2 : 2'h3;
  endfunction

  // status word: clock mode, port counts, clock seen, sequencer state
  function automatic logic [31:0] stat_word(input logic direct,
                                            input logic [1:0] act,
                                            input logic [1:0] fix,
                                            input logic lock,
                                            input logic [1:0] state);
    logic [31:0] w;
    w = 32'h0;
    w[`HCR_STAT_MODE_BIT] = direct;
    w[`HCR_STAT_NP_LSB +: 2] = act;
    w[`HCR_STAT_FIX_LSB +: 2] = fix;
    w[`HCR_STAT_LOCK_BIT] = lock;
    w[`HCR_STAT_ACT_LSB +: 2] = state;
    return w;
  endfunction

  // an access is taken once, in the first cycle of its access phase
  assign acc_take = psel && penable && !rdy_r;
  assign hit_ctrl = apb_hit(paddr, `HCR_ADDR_CTRL);
  assign hit_stat = apb_hit(paddr, `HCR_ADDR_STAT);

  // a 12 MHz tick only counts once the reference has been seen toggling
  assign settle_tick = pll_lock && tick12;

  // startup sequence: latch straps, wait for clock, then run
  always_comb begin
    st_nxt = st_r;
    cmode_nxt = cmode_r;
    np3_nxt = np3_r;
    fix_nxt = fix_r;
    hold_nxt = hold_r;
    unique case (st_r)
      HCR_ST_RESET: begin
        // straps captured on the first clocked edge after release
        cmode_nxt = mode_strap ? HCR_DIRECT_CLK : HCR_PLL_CLK;
        np3_nxt = three_port_select_n;
        fix_nxt = fixed_port_count;
        st_nxt = HCR_ST_SETTLE;
      end
      HCR_ST_SETTLE: begin
        // core waits for some 12 MHz ticks before leaving settle
        if (settle_tick) begin
          hold_nxt = hold_r + 4'h1;
        end
        if (hold_r == `HCR_SETTLE_TICKS) begin
          st_nxt = HCR_ST_RUN;
        end
      end
      HCR_ST_RUN: begin
        if (ctrl_r[`HCR_CTRL_SUSP_BIT]) begin
          st_nxt = HCR_ST_SUSP;
        end
      end
      HCR_ST_SUSP: begin
        if (!ctrl_r[`HCR_CTRL_SUSP_BIT]) begin
          st_nxt = HCR_ST_RUN;
        end
      end
    endcase
  end

  // outputs: enables only for existing ports, suspend flag from state
  always_comb begin
    pwr_n_nxt = ~(ctrl_r[2:0] & port_mask(np3_r));
    if (st_r != HCR_ST_RUN) begin
      pwr_n_nxt = 3'h7; // ports unpowered until running
    end
    susp_nxt = (st_r == HCR_ST_SUSP);
    act_nxt = port_total(np3_r);
  end

  // apb slave, one wait state, unmapped address answers with error
  always_comb begin
    ctrl_nxt = ctrl_r;
    rd_nxt = rd_r;
    rdy_nxt = 1'b0;
    err_nxt = 1'b0;
    if (acc_take) begin
      rdy_nxt = 1'b1;
      if (hit_ctrl) begin
        if (pwrite) begin
          ctrl_nxt = pwdata[3:0];
        end else begin
          rd_nxt = {28'h0, ctrl_r};
        end
      end else if (hit_stat) begin
        rd_nxt = stat_word(mode_direct, act_r, fix_r, pll_lock,
                           st_r[1:0]);
        err_nxt = pwrite; // status is read-only
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  // sequencer and latched straps return to their start on reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= HCR_ST_RESET;
      cmode_r <= HCR_PLL_CLK;
      np3_r <= 1'b0;
      fix_r <= 2'h0;
      hold_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      cmode_r <= cmode_nxt;
      np3_r <= np3_nxt;
      fix_r <= fix_nxt;
      hold_r <= hold_nxt;
    end
  end

  // pin outputs; ports held off in reset so switches never glitch on
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwr_n_r <= 3'h7;
      susp_r <= 1'b0;
      act_r <= 2'h3;
    end else begin
      pwr_n_r <= pwr_n_nxt;
      susp_r <= susp_nxt;
      act_r <= act_nxt;
    end
  end

  // control register and bus response
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= `HCR_CTRL_RST;
      rd_r <= 32'h0;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rd_r <= rd_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
    end
  end

  assign port_power_enable_n = pwr_n_r;
  assign suspend_status_out = susp_r;
  assign crystal_drive_out = xdrv;
  assign active_port_count = act_r;
  assign fixed_port_report = fix_r;
  assign prdata = rd_r;
  assign pready = rdy_r;
  assign pslverr = err_r;
endmodule

// *** sim/hcr_board.sv ***
// board model: strap levels and the reference oscillator
`timescale 1ns/100ps
module hcr_board (
  input wire logic [3:0] cfg,
  output logic mode_strap,
  output logic three_port_select_n,
  output logic [1:0] fixed_port_count,
  output logic reference_clock_in
);
  // straps are fixed levels; the bench moves them only under reset
  assign mode_strap = cfg[3];
  assign three_port_select_n = cfg[2];
  assign fixed_port_count = cfg[1:0];
  // free-running, so reset always ends with a live clock
  initial begin
    reference_clock_in = 1'b0;
    forever #(mode_strap === 1'b1 ? 10.4 : 83.3)
      reference_clock_in = ~reference_clock_in;
  end
endmodule

// *** sim/hcr_control_checker.sv ***
// port assertions for the hub clock/reset/strap block
`timescale 1ns/100ps
module hcr_control_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mode_strap,
  input wire logic three_port_select_n,
  input wire logic [1:0] fixed_port_count,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire hcr_pkg::hcr_port_mask_t port_power_enable_n,
  input wire logic suspend_status_out,
  input wire logic crystal_drive_out,
  input wire logic [1:0] active_port_count,
  input wire logic [1:0] fixed_port_report
);
  import hcr_pkg::*;
  logic [1:0] age_r, age_nxt;
  // cycles since release; straps settle well before age 3
  always_comb age_nxt = age_r + {1'b0, age_r != 2'h3};
  always_ff @(posedge clk_sys or posedge reset)
    age_r <= reset ? 2'h0 : age_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_ACK: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RESET: assert property (disable iff (1'b0) reset |->
    port_power_enable_n == 3'h7 && !suspend_status_out && !pready)
    else $error("state kept in reset");
  AST_PORTS: assert property (age_r == 2'h3 |->
    active_port_count == (three_port_select_n ? 2'h2 : 2'h3))
    else $error("port count");
  AST_FIXED: assert property (age_r == 2'h3 |->
    fixed_port_report == fixed_port_count) else $error("fixed count");
  AST_DIRECT: assert property (age_r == 2'h3 && mode_strap |->
    !crystal_drive_out) else $error("drive in direct mode");
  AST_SUSP: assert property (suspend_status_out |->
    port_power_enable_n == 3'h7) else $error("power in suspend");
  AST_XTAL: assert property (age_r == 2'h3 && !mode_strap |->
    ##[1:8] $changed(crystal_drive_out)) else $error("no crystal drive");
  cover property (port_power_enable_n != 3'h7);
  cover property (pslverr);
  cover property (suspend_status_out);
  cover property (active_port_count == 2'h2);
endmodule
bind hcr_control hcr_control_checker u_hcr_control_checker (.clk_sys,
  .reset, .mode_strap, .three_port_select_n, .fixed_port_count, .psel,
  .penable, .pready, .pslverr, .port_power_enable_n, .suspend_status_out,
  .crystal_drive_out, .active_port_count, .fixed_port_report);

// *** sim/hub_clock_reset_strap_control_tb.sv ***
// self-checking bench for the hub clock/reset/strap block
`timescale 1ns/100ps
`include "hcr_defines.svh"
module hub_clock_reset_strap_control_tb;
  import hcr_pkg::*;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, e, sus, xd;
  logic mode_strap, np_n, ref_clk;
  logic [1:0] apc, fpr, fix;
  logic [3:0] cfg, d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  hcr_port_mask_t pwr;
  int n_fail, total_checks, seed, i, k;
  hcr_board u_hcr_board (.cfg, .mode_strap, .three_port_select_n(np_n),
    .fixed_port_count(fix), .reference_clock_in(ref_clk));
  hcr_control u_hcr_control (.clk_sys, .reset, .mode_strap,
    .three_port_select_n(np_n), .fixed_port_count(fix),
    .reference_clock_in(ref_clk), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .port_power_enable_n(pwr),
    .suspend_status_out(sus), .crystal_drive_out(xd),
    .active_port_count(apc), .fixed_port_report(fpr));
  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  function logic [2:0] exp_pwr(input logic [2:0] on, input logic np);
    return ~(on & (np ? 3'h3 : 3'h7));
  endfunction
  task chk(input logic [31:0] seen, exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    chk(pready, 1'b1, "pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset with new straps; also catches state left from the last run
  task run_cfg(input logic [3:0] c, input int n_hold);
    int t;
    reset <= 1'b1;
    cfg <= c;
    repeat (n_hold) @(posedge clk_sys);
    chk(pwr, 3'h7, "pwr in reset");
    chk(sus, 1'b0, "suspend in reset");
    reset <= 1'b0;
    t = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      t++;
    end while (q[7:6] !== 2'h2 && t < 1000);
    chk(q[7:0], {3'h5, c[1:0], c[2] ? 2'h2 : 2'h3, c[3]}, "stat");
    chk(apc, c[2] ? 2'h2 : 2'h3, "ports");
    chk(fpr, c[1:0], "fixed");
    if (c[3]) chk(xd, 1'b0, "xtal drive");
    apb(1'b1, 12'h000, {28'h0, 1'b0, d[2:0]});
    repeat (2) @(posedge clk_sys);
    chk(pwr, exp_pwr(d[2:0], c[2]), "pwr");
    apb(1'b1, 12'h000, {28'h0, 1'b1, d[2:0]});
    repeat (2) @(posedge clk_sys);
    chk(sus, 1'b1, "suspend");
    chk(pwr, 3'h7, "pwr suspended");
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk(e, 1'b1, "unmapped");
    apb(1'b1, 12'h004, 32'h0);
    chk(e, 1'b1, "stat write");
    apb(1'b0, 12'h000, 32'h0);
    chk(q, {28'h0, 1'b1, d[2:0]}, "ctrl");
    apb(1'b1, 12'h000, {28'h0, 1'b0, d[2:0]});
    repeat (2) @(posedge clk_sys);
    chk(sus, 1'b0, "resume");
    $display("straps %h done", c);
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // corner straps first, random ones after
  initial begin
    {seed, n_fail, total_checks} = {32'd10, 64'd0};
    {reset, psel, penable, pwrite} = 4'h8;
    {paddr, pwdata, cfg, d} = 52'h0;
    for (i = 0; i < 8; i++) begin
      k = $random(seed);
      d = i < 2 ? 4'h7 : k[7:4];
      // one mid-run reset lasts a full 100 us pulse
      run_cfg(i < 4 ? 4'(i * 5) : k[3:0],
        i == 1 ? `HCR_RST_CYC : 5);
    end
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end
endmodule
